// *** core/acwd_pkg.sv ***
/*
 * package for the command word decoder: register map, field layout,
 * channel codes, sequencer states and the decoded-word carrier.
 * assumes a single 125 mhz clock domain.
 */
`default_nettype none
package acwd_pkg;
    // wishbone map: table words at 0x000..0x0fc, control/status above
    localparam logic [8:0] TABLE_BASE = 9'h000;
    localparam logic [8:0] CTRL_OFFS = 9'h100;
    localparam logic [8:0] STAT_OFFS = 9'h104;
    localparam int TABLE_DEPTH = 64;
    localparam int WORD_BITS = 10;
    localparam logic [9:0] WORD_RESET = 10'h000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // command word fields
    localparam int PAUSE_POS = 9;
    localparam int SKIP_POS = 8;
    localparam int STIME_LSB = 6;
    localparam int INPUT_SELECT_LSB = 0;
    // control bit positions
    localparam int CTRL_RUN_POS = 0;
    localparam int CTRL_MUX_POS = 1;
    localparam int CTRL_SWMODE_POS = 2;
    localparam int CTRL_TRIG_POS = 3;
    // channel codes
    localparam logic [5:0] CH_EOQ = 6'h3f;
    localparam logic [5:0] CH_VRL = 6'h3c;
    localparam logic [5:0] CH_VRH = 6'h3d;
    localparam logic [5:0] CH_MID = 6'h3e;
    localparam logic [5:0] CH_PA0 = 6'h34;
    localparam logic [5:0] CH_PA1 = 6'h35;
    localparam logic [5:0] CH_PA3 = 6'h37;
    localparam logic [5:0] CH_PA4 = 6'h38;
    // conversion length past sampling, in converter cycles
    localparam logic [4:0] CONV_CYCLES = 5'h0a;
    // input select codes driven to the analog mux
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_PB0 = 4'h1;
    localparam logic [3:0] SEL_PA0 = 4'h5;
    localparam logic [3:0] SEL_PA1 = 4'h6;
    localparam logic [3:0] SEL_PA3 = 4'h7;
    localparam logic [3:0] SEL_PA4 = 4'h8;
    localparam logic [3:0] SEL_VRL = 4'h9;
    localparam logic [3:0] SEL_VRH = 4'ha;
    localparam logic [3:0] SEL_MID = 4'hb;

    typedef struct packed {
        logic pause;
        logic amp_skip;
        logic [4:0] sample_cycles;
        logic [5:0] input_select;
        logic end_of_queue;
        logic internal_ref;
        logic valid_input_select;
        logic [3:0] analog_sel;
        logic [1:0] mux_addr;
    } acwd_dec_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_FETCH = 5'b00010,
        ST_SAMPLE = 5'b00100,
        ST_CONVERT = 5'b01000,
        ST_PAUSE = 5'b10000
    } acwd_state_type;
endpackage
`default_nettype wire

// *** core/acwd_decode.sv ***
/*
 * combinational decode of one command word into pause, skip, sample
 * window, channel class, analog input select and external mux address.
 * assumes the word and mode bit are stable from the same clock domain.
 */
`default_nettype none
module acwd_decode (
    // word and mode
    input wire logic [9:0] i_word,
    input wire logic i_muxed,
    // decoded result
    output var acwd_pkg::acwd_dec_type o_dec
);
    import acwd_pkg::*;

    logic [5:0] ch;
    logic [1:0] stime;
    assign ch = i_word[INPUT_SELECT_LSB +: 6];
    assign stime = i_word[STIME_LSB +: 2];

    // channel classification and mapping
    always_comb begin
        o_dec = '0;
        o_dec.pause = i_word[PAUSE_POS];
        o_dec.amp_skip = i_word[SKIP_POS];
        o_dec.input_select = ch;
        o_dec.sample_cycles = 5'h02 << stime; // 2,4,8,16
        o_dec.end_of_queue = (ch == CH_EOQ);
        o_dec.internal_ref = (ch == CH_VRL) || (ch == CH_VRH) || (ch == CH_MID);
        o_dec.valid_input_select = 1'b1;
        o_dec.mux_addr = 2'h0;
        // reference channels need no amplifier, same in both modes
        if (ch == CH_VRL) begin
            o_dec.analog_sel = SEL_VRL;
        end else if (ch == CH_VRH) begin
            o_dec.analog_sel = SEL_VRH;
        end else if (ch == CH_MID) begin
            o_dec.analog_sel = SEL_MID;
        end else if (ch == CH_PA3) begin
            o_dec.analog_sel = SEL_PA3;
        end else if (ch == CH_PA4) begin
            o_dec.analog_sel = SEL_PA4;
        end else if (!i_muxed && ch[5:2] == 4'h0) begin
            o_dec.analog_sel = SEL_PB0 + {2'h0, ch[1:0]};
        end else if (!i_muxed && ch == CH_PA0) begin
            o_dec.analog_sel = SEL_PA0;
        end else if (!i_muxed && ch == CH_PA1) begin
            o_dec.analog_sel = SEL_PA1;
        end else if (i_muxed && ch[5] == 1'b0 && ch[3] == 1'b0) begin
            // 000xxy / 010xxy: bit0 and bit4 pick the port b pin
            o_dec.analog_sel = SEL_PB0 + {2'h0, ch[4], ch[0]};
            o_dec.mux_addr = ch[2:1];
        end else begin
            o_dec.analog_sel = SEL_NONE; // reserved, result undefined
            o_dec.valid_input_select = 1'b0;
        end
        if (ch == CH_EOQ) begin
            o_dec.valid_input_select = 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** core/acwd_top.sv ***
/*
 * command word table with a small queue sequencer that walks it,
 * pausing, ending at the end code and driving the mux address pins.
 * assumes a classic wishbone master on the same 125 mhz clock and an
 * analog front end that follows o_analog_sel / o_sampling.
 */
// Functional notes
// - bit 9 pauses the queue after this word's conversion
// - pause 1 halts after current word, 0 continues to next
// - trigger in pause resumes at the word after the pausing one
// - pause ignored in software mode
// - bit 8 bypass is decoded as amp_skip but does not shorten the sample window
// - bypass bit stored for compatibility, no effect here
// - bits 7-6 give sample window 2, 4, 8 or 16 cycles
// - bits 5-0 choose the analog input to convert
// - channel 63 ends the queue, no conversion
// - channels 60-62 convert references directly, no amplifier
// - longer sample code on references only lengthens conversion
// - scanning identical in muxed and non-muxed modes
// - non-muxed: 0-3 port b, 52,53,55,56 port a
// - muxed: four external channels per port b pin, bits 2-1 address
// - unassigned channels are reserved with undefined result
// - table of 64 words, low 10 bits kept, hardware never writes
// - result goes to the entry with the command word's index
`default_nettype none
module acwd_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [8:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // trigger pin, asynchronous
    input wire logic i_trigger,
    // analog front end and result write
    output logic [3:0] o_analog_sel,
    output logic o_sampling,
    output logic o_amp_used,
    output logic o_result_we,
    output logic [5:0] o_result_idx,
    // external mux address pins
    output logic o_ext_mux_addr_bit0,
    output logic o_ext_mux_addr_bit1,
    output logic o_ext_mux_addr_oe
);
    import acwd_pkg::*;

    logic [9:0] table_mem [TABLE_DEPTH];
    logic [31:0] ctrl_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic trig_s1_r, trig_s2_r, trig_d_r;
    logic trig_evt;
    acwd_state_type state_r;
    logic [5:0] ptr_r;
    logic [9:0] word_r;
    logic [4:0] cnt_r;
    logic [3:0] sel_r;
    logic [1:0] maddr_r;
    logic res_we_r;
    logic [5:0] res_idx_r;
    logic amp_r;
    acwd_pkg::acwd_dec_type dec;
    logic bus_req, wr_req, tab_hit;
    logic muxed, swmode;

    assign bus_req = i_wb_cyc && i_wb_stb && !ack_r;
    assign wr_req = bus_req && i_wb_we;
    assign tab_hit = (i_wb_adr[8] == TABLE_BASE[8]);
    assign muxed = ctrl_r[CTRL_MUX_POS];
    assign swmode = ctrl_r[CTRL_SWMODE_POS];

    acwd_decode u_dec (
        .i_word(word_r),
        .i_muxed(muxed),
        .o_dec(dec)
    );

    // single-cycle ack, dropped in the following cycle
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req;
        end
    end

    // table writes: software only, low 10 bits kept
    always_ff @(posedge i_clk_sys) begin
        if (wr_req && tab_hit) begin
            if (i_wb_sel[0]) begin
                table_mem[i_wb_adr[7:2]][7:0] <= i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
                table_mem[i_wb_adr[7:2]][9:8] <= i_wb_dat[9:8]; // bypass stored
            end
        end
    end

    // control register
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_req && i_wb_adr == CTRL_OFFS && i_wb_sel[0]) begin
            ctrl_r <= {28'h0, i_wb_dat[3:0]};
        end else begin
            ctrl_r[CTRL_TRIG_POS] <= 1'b0; // software trigger self-clears
        end
    end

    // read data; unmapped reads return zero
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rdat_r <= 32'h0;
        end else if (bus_req && !i_wb_we) begin
            if (tab_hit) begin
                rdat_r <= {22'h0, table_mem[i_wb_adr[7:2]]};
            end else if (i_wb_adr == CTRL_OFFS) begin
                rdat_r <= ctrl_r;
            end else if (i_wb_adr == STAT_OFFS) begin
                rdat_r <= {19'h0, state_r, 2'h0, ptr_r};
            end else begin
                rdat_r <= 32'h0;
            end
        end
    end
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    // trigger pin sync and rising edge; software trigger also counts
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
        end else begin
            trig_s1_r <= i_trigger;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
        end
    end
    assign trig_evt = (trig_s2_r && !trig_d_r) || ctrl_r[CTRL_TRIG_POS];

    // queue sequencer; same walk whatever the mux mode
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ST_IDLE;
            ptr_r <= 6'h0;
            word_r <= WORD_RESET;
            cnt_r <= 5'h0;
            sel_r <= SEL_NONE;
            maddr_r <= 2'h0;
            amp_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (ctrl_r[CTRL_RUN_POS] && trig_evt) begin
                        ptr_r <= 6'h0;
                        word_r <= table_mem[6'h0];
                        state_r <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (dec.end_of_queue) begin
                        state_r <= ST_IDLE; // stop, nothing converted
                    end else begin
                        // window from bits 7-6; bypass has no effect
                        cnt_r <= dec.sample_cycles - 5'h01;
                        sel_r <= dec.analog_sel;
                        maddr_r <= dec.mux_addr;
                        amp_r <= !dec.internal_ref;
                        state_r <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    // address held for the whole window
                    if (cnt_r == 5'h0) begin
                        cnt_r <= CONV_CYCLES - 5'h01;
                        state_r <= ST_CONVERT;
                    end else begin
                        cnt_r <= cnt_r - 5'h01; // refs: longer, same result
                    end
                end
                ST_CONVERT: begin
                    if (cnt_r != 5'h0) begin
                        cnt_r <= cnt_r - 5'h01;
                    end else if (ptr_r == 6'h3f) begin
                        state_r <= ST_IDLE;
                    end else if (dec.pause && !swmode) begin
                        state_r <= ST_PAUSE;
                    end else begin
                        ptr_r <= ptr_r + 6'h01;
                        word_r <= table_mem[ptr_r + 6'h01];
                        state_r <= ST_FETCH;
                    end
                end
                ST_PAUSE: begin
                    if (!ctrl_r[CTRL_RUN_POS]) begin
                        state_r <= ST_IDLE;
                    end else if (trig_evt) begin
                        ptr_r <= ptr_r + 6'h01; // resume at next word
                        word_r <= table_mem[ptr_r + 6'h01];
                        state_r <= ST_FETCH;
                    end
                end
            endcase
        end
    end

    // result write strobe at the word's own index
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            res_we_r <= 1'b0;
            res_idx_r <= 6'h0;
        end else begin
            res_we_r <= (state_r == ST_CONVERT) && (cnt_r == 5'h0);
            res_idx_r <= ptr_r;
        end
    end

    assign o_result_we = res_we_r;
    assign o_result_idx = res_idx_r;
    assign o_analog_sel = sel_r;
    assign o_sampling = (state_r == ST_SAMPLE);
    assign o_amp_used = amp_r;
    // pins for 52/53 become address outputs only in muxed mode
    assign o_ext_mux_addr_bit0 = maddr_r[0];
    assign o_ext_mux_addr_bit1 = maddr_r[1];
    assign o_ext_mux_addr_oe = muxed;

    // helper count of convert cycles; ten is past what a repetition should unroll
    logic [4:0] conv_seen_r;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            conv_seen_r <= 5'h0;
        end else if (state_r == ST_CONVERT) begin
            conv_seen_r <= conv_seen_r + 5'h01;
        end else begin
            conv_seen_r <= 5'h0;
        end
    end

    // sequencer and bus checks
    a_eoq_no_result: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_FETCH && dec.end_of_queue) |=> state_r == ST_IDLE ##1 !res_we_r)
        else $error("end code started a conversion");
    a_pause_entry: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_CONVERT && cnt_r == 5'h0 && dec.pause && swmode) |=>
        state_r != ST_PAUSE)
        else $error("paused in software mode");
    a_addr_steady: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_SAMPLE && $past(state_r) == ST_SAMPLE) |-> $stable(maddr_r))
        else $error("mux address moved in window");
    a_resume_next: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_PAUSE && ctrl_r[CTRL_RUN_POS] && trig_evt) |=>
        ptr_r == $past(ptr_r) + 6'h01)
        else $error("resume not at next word");
    a_result_index: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_CONVERT && cnt_r == 5'h0) |=> res_we_r && res_idx_r == $past(ptr_r))
        else $error("result index wrong");
    a_ref_no_amp: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_FETCH && dec.internal_ref) |=> !amp_r)
        else $error("reference used amplifier");
    a_window_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_FETCH && !dec.end_of_queue && word_r[7:6] == 2'b01) |=>
        (state_r == ST_SAMPLE) [*4] ##1 state_r == ST_CONVERT)
        else $error("sample window not four cycles");
    a_pause_halt: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_CONVERT && cnt_r == 5'h0 && dec.pause && !swmode && ptr_r != 6'h3f)
        |=> state_r == ST_PAUSE)
        else $error("pause flag did not halt");
    a_reserved_sel: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_FETCH && !dec.valid_input_select && !dec.end_of_queue) |=>
        state_r == ST_SAMPLE && sel_r == SEL_NONE)
        else $error("reserved channel not deselected");
    a_continue_next: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_CONVERT && cnt_r == 5'h0 && !dec.pause && ptr_r != 6'h3f) |=>
        state_r == ST_FETCH && ptr_r == $past(ptr_r) + 6'h01)
        else $error("queue did not continue to next word");
    a_sel_steady: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_SAMPLE && $past(state_r) == ST_SAMPLE) |-> $stable(sel_r))
        else $error("input select moved in window");
    a_amp_nonref: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_FETCH && !dec.end_of_queue && !dec.internal_ref) |=> amp_r)
        else $error("amplifier not used for a pin channel");
    a_start_word: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_IDLE && ctrl_r[CTRL_RUN_POS] && trig_evt) |=>
        state_r == ST_FETCH && ptr_r == 6'h0)
        else $error("queue did not start at word zero");
    a_convert_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == ST_CONVERT && cnt_r == 5'h0) |-> conv_seen_r == CONV_CYCLES - 5'h01)
        else $error("convert phase length wrong");
    a_ack_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ack_r |=> !ack_r)
        else $error("bus ack held past one cycle");
endmodule
`default_nettype wire

// *** verif/acwd_far_model.sv ***
/*
 * far side model: trigger pin source and analog front end capture.
 * assumes the core's sampling window and result strobe on one clock.
 */
`default_nettype none
module acwd_far_model (
    // clock, reset and stimulus
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_fire,
    // core outputs observed
    input wire logic i_sampling,
    input wire logic [3:0] i_sel,
    input wire logic i_amp,
    input wire logic i_we,
    input wire logic [5:0] i_idx,
    input wire logic [1:0] i_addr,
    // trigger pin and capture
    output logic o_trigger,
    output var int o_cnt,
    output var int o_len,
    output var int o_glitch,
    output logic [3:0] o_sel,
    output logic o_amp,
    output logic [1:0] o_addr,
    output logic [5:0] o_idx
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_r;
    logic [2:0] pulse_r;
    // pulse held four cycles so the pin synchroniser cannot miss it
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) pulse_r <= 3'h0;
        else if (i_fire) pulse_r <= 3'h4;
        else if (pulse_r != 3'h0) pulse_r <= pulse_r - 3'h1;
    end
    assign o_trigger = (pulse_r != 3'h0);
    // latch input and mux address at window start, count any change after
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            run_r <= 0;
            o_cnt <= 0;
            o_len <= 0;
            o_glitch <= 0;
            o_sel <= 4'h0;
            o_amp <= 1'b0;
            o_addr <= 2'h0;
            o_idx <= 6'h00;
        end else begin
            if (i_sampling) begin
                run_r <= run_r + 1;
                if (run_r == 0) begin
                    o_sel <= i_sel;
                    o_amp <= i_amp;
                    o_addr <= i_addr;
                end else if (i_addr !== o_addr || i_sel !== o_sel) begin
                    o_glitch <= o_glitch + 1;
                end
            end
            if (i_we) begin
                o_cnt <= o_cnt + 1;
                o_len <= run_r;
                o_idx <= i_idx;
                run_r <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/acwd_top_tb.sv ***
/*
 * self-checking bench for the command word decoder and sequencer.
 * assumes the wishbone map and control bits of the package.
 */
`default_nettype none
module acwd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acwd_pkg::*;
    logic clk, rstn, cyc, stb, we, fire;
    logic [8:0] adr;
    logic [3:0] sel, as, asel;
    logic [31:0] wdat, rdat, q;
    logic ack, samp, amp, rwe, a0, a1, oe, trig, aamp;
    logic [5:0] ridx, aidx;
    logic [1:0] aaddr;
    int cnt, len, glitch, seen, failures, samples_checked, cycles;
    acwd_top dut (.i_clk_sys(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_trigger(trig), .o_analog_sel(as), .o_sampling(samp),
        .o_amp_used(amp), .o_result_we(rwe), .o_result_idx(ridx),
        .o_ext_mux_addr_bit0(a0), .o_ext_mux_addr_bit1(a1), .o_ext_mux_addr_oe(oe));
    acwd_far_model far (.i_clk_sys(clk), .i_rstn(rstn), .i_fire(fire), .i_sampling(samp),
        .i_sel(as), .i_amp(amp), .i_we(rwe), .i_idx(ridx), .i_addr({a1, a0}),
        .o_trigger(trig), .o_cnt(cnt), .o_len(len), .o_glitch(glitch), .o_sel(asel),
        .o_amp(aamp), .o_addr(aaddr), .o_idx(aidx));
    // free-running clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, far above the thousand or so cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures = failures + 1;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask
    // one classic cycle; ack is taken at the edge that samples it high
    task automatic wb(input logic [8:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) chk(1'b0, "bus ack missing");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic start(input logic mux, input logic swm);
        wb(CTRL_OFFS, 1'b1, {28'h0, 1'b1, swm, mux, 1'b1});
    endtask
    // waits for the next result and compares the capture with expectation
    task automatic res(input logic [5:0] i, input logic [3:0] s, input logic am,
        input logic mux, input logic [1:0] ad, input int ln);
        int n;
        n = 0;
        while (cnt == seen && n < 200) begin
            @(posedge clk);
            n++;
        end
        seen = cnt;
        chk(n < 200 && aidx === i, "result index");
        chk(asel === s && aamp === am, "input select or amplifier use");
        chk(len == ln, "sample window length");
        if (mux) chk(aaddr === ad && oe === 1'b1 && glitch == 0, "mux address");
        else chk(oe === 1'b0, "address pins driven outside muxed mode");
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge clk);
        chk(cnt == seen, "unexpected result write");
    endtask
    task automatic t_regs();
        wb(9'h014, 1'b1, 32'hffff_ffff);
        wb(9'h014, 1'b0, 32'h0);
        chk(q === 32'h0000_03ff, "table word width");
        wb(9'h108, 1'b0, 32'h0);
        chk(q === 32'h0, "unmapped read");
    endtask
    task automatic t_window();
        for (int k = 0; k < 4; k++) begin
            wb(TABLE_BASE, 1'b1, {22'h0, 1'b0, k[0], k[1:0], 6'd2});
            wb(9'h004, 1'b1, {22'h0, 4'h0, CH_EOQ});
            start(1'b0, 1'b1);
            res(6'd0, SEL_PB0 + 4'h2, 1'b1, 1'b0, 2'h0, 2 << k);
            quiet(40);
        end
    endtask
    task automatic t_chans();
        logic [5:0] ch[7] = '{6'd52, 6'd53, 6'd55, 6'd56, CH_VRL, CH_VRH, CH_MID};
        logic [3:0] es[7] = '{SEL_PA0, SEL_PA1, SEL_PA3, SEL_PA4, SEL_VRL, SEL_VRH, SEL_MID};
        for (int i = 0; i < 7; i++) wb(9'(4 * i), 1'b1, {22'h0, 4'h3, ch[i]});
        wb(9'h01c, 1'b1, {22'h0, 4'h0, CH_EOQ});
        start(1'b0, 1'b1);
        for (int i = 0; i < 7; i++) res(6'(i), es[i], i < 4, 1'b0, 2'h0, 16);
        quiet(40);
    endtask
    task automatic t_pause();
        wb(TABLE_BASE, 1'b1, {22'h0, 4'h8, 6'd0});
        wb(9'h004, 1'b1, {22'h0, 4'h0, 6'd1});
        wb(9'h008, 1'b1, {22'h0, 4'h0, CH_EOQ});
        start(1'b0, 1'b0);
        res(6'd0, SEL_PB0, 1'b1, 1'b0, 2'h0, 2);
        quiet(60);
        wb(STAT_OFFS, 1'b0, 32'h0);
        chk(q === 32'h0000_1000, "pause state or pointer in status");
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        res(6'd1, SEL_PB0 + 4'h1, 1'b1, 1'b0, 2'h0, 2);
        quiet(40);
        start(1'b0, 1'b1);
        res(6'd0, SEL_PB0, 1'b1, 1'b0, 2'h0, 2);
        res(6'd1, SEL_PB0 + 4'h1, 1'b1, 1'b0, 2'h0, 2);
    endtask
    task automatic t_muxed();
        wb(TABLE_BASE, 1'b1, {22'h0, 4'h1, 6'd6});
        wb(9'h004, 1'b1, {22'h0, 4'h1, 6'd18});
        wb(9'h008, 1'b1, {22'h0, 4'h1, 6'd23});
        wb(9'h00c, 1'b1, {22'h0, 4'h1, 6'd55});
        wb(9'h010, 1'b1, {22'h0, 4'h1, CH_PA0});
        wb(9'h014, 1'b1, {22'h0, 4'h0, CH_EOQ});
        start(1'b1, 1'b1);
        res(6'd0, SEL_PB0, 1'b1, 1'b1, 2'h3, 4);
        res(6'd1, SEL_PB0 + 4'h2, 1'b1, 1'b1, 2'h1, 4);
        res(6'd2, SEL_PB0 + 4'h3, 1'b1, 1'b1, 2'h3, 4);
        res(6'd3, SEL_PA3, 1'b1, 1'b1, 2'h0, 4);
        res(6'd4, SEL_NONE, 1'b1, 1'b1, 2'h0, 4);
        quiet(40);
    endtask
    initial begin
        rstn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 9'h000;
        sel = 4'h0;
        wdat = 32'h0;
        fire = 1'b0;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        seen = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_window();
        t_chans();
        t_pause();
        t_muxed();
        conclude();
    end
endmodule
`default_nettype wire
